// [rtl/rx_chain_defines.vh]
// constants for the receiver chain control register bank
// assumes a 4-wire serial port, 15-bit address, 8-bit data, mode 0
//
// Contract
// RL1: switch source bit 6 picks pins or register
// RL2: switch source bit resets to pin control
// RL3: register mode: 10 input 0, 01 input 1; code maps bits 5..4 = 10 to input 1 and 01 to input 0
// RL4: pin mode follows pins, ignores register bits
// RL5: attenuation code bits 5..2, 1 dB steps
// RL6: attenuator enabled only while bit 0 set
// RL7: gain peaking amount bits 1..0 applied
// RL8: host writes documented demodulator enable values
// RL9: four sign-magnitude dc offset code registers
// RL10: bits 1 and 2 invert I and Q
// RL11: lowpass code bits 1..0 select bandwidth
// RL12: bits 0 and 1 enable I, Q amps
// RL13: lo divider code bits 4..0 one-hot ratio
// RL14: integer divider low write starts autotune
// RL15: master enable gates signal-chain enables only; code also gates lo_output_enable
// RL16: host enables lo output after lock
// RL17: all settings held in serial-accessible registers
// RL18: equal select bits keep previous input
`ifndef RX_CHAIN_DEFINES_VH
`define RX_CHAIN_DEFINES_VH

// register addresses
`define ADDR_MASTER_ENABLE 16'h0020
`define ADDR_RF_SWITCH 16'h0030
`define ADDR_ATTEN 16'h0031
`define ADDR_DEMOD_EN 16'h0032
`define ADDR_MIX_LO_CM 16'h0033
`define ADDR_MIX_OUT_CM 16'h0034
`define ADDR_GAIN_PEAK 16'h003A
`define ADDR_CM_EN 16'h0040
`define ADDR_DC_CH0_I 16'h0051
`define ADDR_DC_CH0_Q 16'h0052
`define ADDR_DC_CH1_I 16'h0053
`define ADDR_DC_CH1_Q 16'h0054
`define ADDR_LOWPASS 16'h0060
`define ADDR_IF_AMP 16'h0070
`define ADDR_POLARITY 16'h0080
`define ADDR_INT_DIV_LOW 16'h1200
`define ADDR_LO_OUT_DIV 16'h1414

// storage slots in the register memory
`define SLOT_COUNT 16
`define SLOT_NONE 5'h10

// field positions
`define BIT_MASTER_EN 1
`define BIT_SW_SOURCE 6
`define BIT_SW_SEL1 5
`define BIT_SW_SEL0 4
`define BIT_ATTEN_EN 0
`define ATTEN_HI 5
`define ATTEN_LO 2
`define BIT_I_INV 1
`define BIT_Q_INV 2
`define BIT_LO_OUTPUT_ENABLE 6

// reset values
`define RESET_BYTE 8'h00

// lowpass bandwidth selection codes
`define LPF_1000MHZ 2'h0
`define LPF_750MHZ 2'h1
`define LPF_500MHZ 2'h2
`define LPF_250MHZ 2'h3

// one-hot lo divider codes
`define DIV_BY_8 5'h08
`define DIV_BY_4 5'h04
`define DIV_BY_2 5'h02
`define DIV_BY_1 5'h01

// serial frame: read flag, 15 address bits, 8 data bits
`define FRAME_BITS 24
`define DATA_START 16

`endif

// [rtl/reg_memory.v]
// small byte memory holding the settings registers
// assumes one write port and a registered read port on one clock
`timescale 1ns/10ps
`default_nettype none
`include "rx_chain_defines.vh"

module reg_memory (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // write port
    input wire wr_en,
    input wire [3:0] wr_slot,
    input wire [7:0] wr_data,
    // registered read port
    input wire [3:0] rd_slot,
    output reg [7:0] rd_data_q,
    // all contents, flat, slot 0 in the low byte
    output wire [8*`SLOT_COUNT-1:0] contents
);
    reg [7:0] mem_q [0:`SLOT_COUNT-1]; // flops so every byte resets
    genvar g;

    // each slot is its own register and drives its own lane
    generate
        for (g = 0; g < `SLOT_COUNT; g = g + 1) begin : slot
            always @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    mem_q[g] <= `RESET_BYTE;
                end else if (wr_en && wr_slot == g) begin
                    mem_q[g] <= wr_data;
                end
            end
            assign contents[8*g+7:8*g] = mem_q[g];
        end
    endgenerate

    // read data come out of a flop
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= `RESET_BYTE;
        end else begin
            rd_data_q <= mem_q[rd_slot];
        end
    end
endmodule
`default_nettype wire

// [rtl/serial_port.v]
// serial slave: 24-bit frames, msb first, sampled on rising sclk
// assumes sclk, sdi, cs_n synchronous to ref_clk and slower than it
`timescale 1ns/10ps
`default_nettype none
`include "rx_chain_defines.vh"

module serial_port (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // serial pins
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    output reg sdo_q,
    // register side
    output reg [15:0] addr_q,
    output reg addr_valid_q,
    output reg wr_stb_q,
    output reg [7:0] wr_data_q,
    input wire [7:0] rd_data
);
    reg sclk_q; // previous sclk for edge detect
    reg [4:0] count_q; // bits taken in this frame
    reg [23:0] shift_q; // incoming bits
    reg [7:0] out_q; // outgoing read byte
    reg is_read_q;
    wire rise = sclk && !sclk_q;
    wire fall = !sclk && sclk_q;
    wire [23:0] shifted = {shift_q[22:0], sdi};

    // frame engine; cs_n high aborts a partial frame
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sclk_q <= 1'b0;
            count_q <= 5'h00;
            shift_q <= 24'h000000;
            out_q <= 8'h00;
            is_read_q <= 1'b0;
            sdo_q <= 1'b0;
            addr_q <= 16'h0000;
            addr_valid_q <= 1'b0;
            wr_stb_q <= 1'b0;
            wr_data_q <= 8'h00;
        end else begin
            sclk_q <= sclk;
            wr_stb_q <= 1'b0;
            if (cs_n) begin
                count_q <= 5'h00;
                addr_valid_q <= 1'b0;
                sdo_q <= 1'b0;
            end else if (rise) begin
                shift_q <= shifted;
                count_q <= count_q + 5'h01;
                if (count_q == 5'h0F) begin
                    // address complete: top bit flags a read
                    addr_q <= {1'b0, shifted[14:0]};
                    is_read_q <= shifted[15];
                    addr_valid_q <= 1'b1;
                end
                if (count_q == 5'h17 && !is_read_q) begin
                    wr_data_q <= shifted[7:0];
                    wr_stb_q <= 1'b1;
                end
            end else if (fall) begin
                // read byte is loaded once the memory flop has settled
                if (count_q == 5'h10 && is_read_q) begin
                    out_q <= {rd_data[6:0], 1'b0};
                    sdo_q <= rd_data[7];
                end else if (count_q > 5'h10 && is_read_q) begin
                    sdo_q <= out_q[7];
                    out_q <= {out_q[6:0], 1'b0};
                end
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/rx_chain_control_regs.v]
// receiver chain control register bank with serial access
// assumes host drives serial pins and switch select pins synchronously
`timescale 1ns/10ps
`default_nettype none
`include "rx_chain_defines.vh"

module rx_chain_control_regs (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // serial port
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    output wire sdo,
    // switch select pins
    input wire input0_select_pin,
    input wire input1_select_pin,
    // rf switch
    output reg rf_input_zero,
    output reg rf_input_one,
    // step attenuator
    output reg [3:0] attenuation_code,
    output reg attenuator_enable,
    // mixer and common mode
    output reg [1:0] gain_peak,
    output reg [7:0] demod_enables,
    output reg [7:0] common_mode_enables,
    output reg [7:0] mixer_lo_cm,
    output reg [7:0] mixer_out_cm,
    // dc offset codes, sign-magnitude
    output reg [7:0] dc_offset_ch0_i,
    output reg [7:0] dc_offset_ch0_q,
    output reg [7:0] dc_offset_ch1_i,
    output reg [7:0] dc_offset_ch1_q,
    // polarity and filter
    output reg i_path_invert,
    output reg q_path_invert,
    output reg [1:0] lowpass_bw_sel,
    // if amplifiers
    output reg i_amp_enable,
    output reg q_amp_enable,
    // lo output
    output reg [4:0] lo_divider_code,
    output reg [2:0] lo_divide_ratio_log2,
    output reg lo_output_enable,
    // synthesizer
    output reg autotune_start
);
    // map an address to a storage slot; shared by write and read paths
    function [4:0] slot_of;
        input [15:0] a;
        begin
            case (a)
                `ADDR_MASTER_ENABLE: slot_of = 5'h00;
                `ADDR_RF_SWITCH: slot_of = 5'h01;
                `ADDR_ATTEN: slot_of = 5'h02;
                `ADDR_DEMOD_EN: slot_of = 5'h03;
                `ADDR_MIX_LO_CM: slot_of = 5'h04;
                `ADDR_MIX_OUT_CM: slot_of = 5'h05;
                `ADDR_GAIN_PEAK: slot_of = 5'h06;
                `ADDR_CM_EN: slot_of = 5'h07;
                `ADDR_DC_CH0_I: slot_of = 5'h08;
                `ADDR_DC_CH0_Q: slot_of = 5'h09;
                `ADDR_DC_CH1_I: slot_of = 5'h0A;
                `ADDR_DC_CH1_Q: slot_of = 5'h0B;
                `ADDR_LOWPASS: slot_of = 5'h0C;
                `ADDR_IF_AMP: slot_of = 5'h0D;
                `ADDR_POLARITY: slot_of = 5'h0E;
                `ADDR_INT_DIV_LOW: slot_of = 5'h0F;
                default: slot_of = `SLOT_NONE;
            endcase
        end
    endfunction

    // one-hot divider code to log2 ratio; illegal codes fall to divide by 1
    function [2:0] ratio_of;
        input [4:0] c;
        begin
            case (c)
                `DIV_BY_8: ratio_of = 3'h3;
                `DIV_BY_4: ratio_of = 3'h2;
                `DIV_BY_2: ratio_of = 3'h1;
                `DIV_BY_1: ratio_of = 3'h0;
                default: ratio_of = 3'h0;
            endcase
        end
    endfunction

    // serial side wires
    wire [15:0] bus_addr;
    wire bus_addr_valid;
    wire bus_wr;
    wire [7:0] bus_wdata;
    wire [7:0] mem_rdata;
    wire [8*`SLOT_COUNT-1:0] regs;

    // decode of the current frame address
    wire [4:0] slot = slot_of(bus_addr);
    wire is_lo_div = (bus_addr == `ADDR_LO_OUT_DIV);
    wire mem_wr = bus_wr && !slot[4];

    reg [7:0] lo_div_reg_q; // held outside the memory, steers output now
    reg [7:0] rd_mux; // read byte to the serial port

    serial_port u_serial (
        .ref_clk(ref_clk),
        .reset(reset),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdi(sdi),
        .sdo_q(sdo),
        .addr_q(bus_addr),
        .addr_valid_q(bus_addr_valid),
        .wr_stb_q(bus_wr),
        .wr_data_q(bus_wdata),
        .rd_data(rd_mux)
    );

    reg_memory u_mem (
        .ref_clk(ref_clk),
        .reset(reset),
        .wr_en(mem_wr),
        .wr_slot(slot[3:0]),
        .wr_data(bus_wdata),
        .rd_slot(slot[3:0]),
        .rd_data_q(mem_rdata),
        .contents(regs)
    );

    // the separate lo divider register; all settings readable back
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lo_div_reg_q <= `RESET_BYTE;
        end else if (bus_wr && is_lo_div) begin
            lo_div_reg_q <= bus_wdata; // RL17
        end
    end

    // read path: unmapped addresses read zero
    always @* begin
        if (is_lo_div) begin
            rd_mux = lo_div_reg_q;
        end else if (slot[4] || !bus_addr_valid) begin
            rd_mux = 8'h00;
        end else begin
            rd_mux = mem_rdata; // RL17
        end
    end

    // named views of the stored bytes
    wire [7:0] master_b = regs[7:0];
    wire [7:0] switch_b = regs[15:8];
    wire [7:0] atten_b = regs[23:16];
    wire master_on = master_b[`BIT_MASTER_EN];
    wire from_reg = switch_b[`BIT_SW_SOURCE]; // resets to 0: pin control RL2

    // selected input before gating by the master enable
    reg sel_one_q; // remembered input for the undefined register combination
    reg sel_one_d;

    // switch source choice
    always @* begin
        sel_one_d = sel_one_q;
        if (!from_reg) begin
            // pins rule, register selects are ignored RL4
            if (input1_select_pin && !input0_select_pin) begin
                sel_one_d = 1'b1;
            end else if (input0_select_pin && !input1_select_pin) begin
                sel_one_d = 1'b0;
            end
        end else if (switch_b[`BIT_SW_SEL0] != switch_b[`BIT_SW_SEL1]) begin
            sel_one_d = switch_b[`BIT_SW_SEL1]; // RL3 RL1
        end else begin
            // both equal: keep what was selected RL18
            sel_one_d = sel_one_q;
        end
    end

    // switch memory
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sel_one_q <= 1'b0;
        end else begin
            sel_one_q <= sel_one_d;
        end
    end

    // output flops; master enable gates the chain and the lo driver, never the lo divider
    // rf switch: both low with master off
    // flopped so the switch sees no glitch
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rf_input_zero <= 1'b0;
            rf_input_one <= 1'b0;
        end else begin
            rf_input_zero <= master_on && !sel_one_d; // RL15
            rf_input_one <= master_on && sel_one_d; // RL15
        end
    end

    // step attenuator code and enable
    // code ungated: unused while off
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            attenuation_code <= 4'h0;
            attenuator_enable <= 1'b0;
        end else begin
            attenuation_code <= atten_b[`ATTEN_HI:`ATTEN_LO]; // RL5
            attenuator_enable <= master_on && atten_b[`BIT_ATTEN_EN]; // RL6 RL15
        end
    end

    // mixer gain peaking amount
    // a setting, not an enable
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gain_peak <= 2'h0;
        end else begin
            gain_peak <= regs[49:48]; // RL7
        end
    end

    // demodulator enables
    // mixer and common-mode enables, host loads fixed values
    // enables, so master off clears them
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            demod_enables <= 8'h00;
            common_mode_enables <= 8'h00;
        end else begin
            demod_enables <= master_on ? regs[31:24] : 8'h00; // RL15 RL8
            common_mode_enables <= master_on ? regs[63:56] : 8'h00; // RL15
        end
    end

    // common-mode levels
    // levels pass ungated
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mixer_lo_cm <= 8'h00;
            mixer_out_cm <= 8'h00;
        end else begin
            mixer_lo_cm <= regs[39:32];
            mixer_out_cm <= regs[47:40];
        end
    end

    // offset codes pass through unchanged RL9
    // channel 0, sign-magnitude
    // kept through master off
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dc_offset_ch0_i <= 8'h00;
            dc_offset_ch0_q <= 8'h00;
        end else begin
            dc_offset_ch0_i <= regs[71:64];
            dc_offset_ch0_q <= regs[79:72];
        end
    end

    // channel 1 offset codes
    // same format as channel 0
    // ungated as well
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dc_offset_ch1_i <= 8'h00;
            dc_offset_ch1_q <= 8'h00;
        end else begin
            dc_offset_ch1_i <= regs[87:80];
            dc_offset_ch1_q <= regs[95:88];
        end
    end

    // i and q path polarity
    // set high to invert a path
    // ungated: a setting only
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            i_path_invert <= 1'b0;
            q_path_invert <= 1'b0;
        end else begin
            i_path_invert <= regs[112 + `BIT_I_INV]; // RL10
            q_path_invert <= regs[112 + `BIT_Q_INV]; // RL10
        end
    end

    // lowpass bandwidth code
    // every code is legal
    // 00 widest, 11 narrowest
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lowpass_bw_sel <= `LPF_1000MHZ;
        end else begin
            lowpass_bw_sel <= regs[97:96]; // RL11
        end
    end

    // if amplifier enables
    // gated with the chain
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            i_amp_enable <= 1'b0;
            q_amp_enable <= 1'b0;
        end else begin
            i_amp_enable <= master_on && regs[104]; // RL12 RL15
            q_amp_enable <= master_on && regs[105]; // RL12 RL15
        end
    end

    // lo divider code and ratio
    // illegal codes read as divide by 1
    // lo generation: never gated
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lo_divider_code <= 5'h00;
            lo_divide_ratio_log2 <= 3'h0;
        end else begin
            lo_divider_code <= lo_div_reg_q[4:0]; // RL13
            lo_divide_ratio_log2 <= ratio_of(lo_div_reg_q[4:0]); // RL13
        end
    end

    // lo driver enable
    // a driver, so master gates it
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lo_output_enable <= 1'b0;
        end else begin
            // lo driver enable is gated; host sets it only after lock RL16
            lo_output_enable <= master_on && lo_div_reg_q[`BIT_LO_OUTPUT_ENABLE]; // RL15
        end
    end

    // one-cycle autotune pulse on any write to the integer low byte
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            autotune_start <= 1'b0;
        end else begin
            autotune_start <= bus_wr && (bus_addr == `ADDR_INT_DIV_LOW); // RL14
        end
    end
endmodule
`default_nettype wire

// [dv/host_model.sv]
// host side model: drives serial frames into the register bank
// assumes the bank samples sdi on sclk rise as seen by ref_clk
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // clock
    input wire logic ref_clk,
    // serial pins
    output logic sclk,
    output logic cs_n,
    output wire logic sdi,
    input wire logic sdo
);
    logic bit_q = 1'b0; // frame bit on the line
    logic idle_q = 1'b0; // moving pattern while deselected
    logic [7:0] rd_byte; // last byte read back
    event rd_done; // fires when a read frame ends

    // a deselected data line carries no value, so keep it moving
    assign sdi = cs_n ? idle_q : bit_q;
    always @(negedge ref_clk) begin
        idle_q <= ~idle_q;
    end
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end

    // one frame, msb first, each sclk phase two cycles; sclk idles low
    task automatic xfer(input logic rd, input logic [15:0] addr, input logic [7:0] wd);
        logic [23:0] f;
        f = {rd, addr[14:0], wd};
        @(negedge ref_clk);
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            bit_q = f[i];
            sclk = 1'b0;
            repeat (2) @(negedge ref_clk);
            // read data stands since the last fall
            if (i < 8) rd_byte[i] = sdo;
            sclk = 1'b1;
            repeat (2) @(negedge ref_clk);
        end
        sclk = 1'b0;
        repeat (2) @(negedge ref_clk);
        cs_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        if (rd) -> rd_done;
    endtask
endmodule
`default_nettype wire

// [dv/rx_chain_chk.sv]
// port checker for the receiver chain register bank
// assumes one clock domain and an active high reset
`timescale 1ns/10ps
`default_nettype none
module rx_chain_chk (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // serial and pins
    input wire cs_n,
    input wire sdo,
    input wire input0_select_pin,
    input wire input1_select_pin,
    // watched outputs
    input wire rf_input_zero,
    input wire rf_input_one,
    input wire [3:0] attenuation_code,
    input wire attenuator_enable,
    input wire [1:0] gain_peak,
    input wire i_amp_enable,
    input wire q_amp_enable,
    input wire [4:0] lo_divider_code,
    input wire [2:0] lo_divide_ratio_log2,
    input wire lo_output_enable,
    input wire autotune_start
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    chk_rf_onehot: assert property (!(rf_input_zero && rf_input_one))
        else $error("both rf inputs selected");
    // master off clears the switch, so gated enables need a selected input
    chk_atten_gated: assert property (attenuator_enable |-> rf_input_zero || rf_input_one)
        else $error("attenuator on while master off");
    chk_amp_gated: assert property ((i_amp_enable || q_amp_enable) |-> rf_input_zero || rf_input_one)
        else $error("amplifier on while master off");
    chk_lo_gated: assert property (lo_output_enable |-> rf_input_zero || rf_input_one)
        else $error("lo output on while master off");
    chk_tune_pulse: assert property ($rose(autotune_start) |=> $fell(autotune_start))
        else $error("autotune pulse longer than one cycle");
    chk_div_eight: assert property (lo_divider_code == 5'h08 |-> lo_divide_ratio_log2 == 3'h3)
        else $error("divide by eight ratio wrong");
    chk_div_four: assert property (lo_divider_code == 5'h04 |-> lo_divide_ratio_log2 == 3'h2)
        else $error("divide by four ratio wrong");
    chk_sdo_idle: assert property (cs_n && $past(cs_n) |-> !sdo)
        else $error("sdo driven while deselected");
    // without a frame only the pins may move the switch
    chk_switch_hold: assert property ($stable(input0_select_pin) && $stable(input1_select_pin)
        && cs_n && $past(cs_n) |=> $stable(rf_input_zero) && $stable(rf_input_one))
        else $error("switch moved with no cause");
    chk_code_hold: assert property (cs_n && $past(cs_n) |=> $stable(attenuation_code)
        && $stable(gain_peak))
        else $error("setting moved with no write");
endmodule
bind rx_chain_control_regs rx_chain_chk chk (.ref_clk, .reset, .cs_n, .sdo, .input0_select_pin,
    .input1_select_pin, .rf_input_zero, .rf_input_one, .attenuation_code, .attenuator_enable,
    .gain_peak, .i_amp_enable, .q_amp_enable, .lo_divider_code, .lo_divide_ratio_log2,
    .lo_output_enable, .autotune_start);
`default_nettype wire

// [dv/rx_chain_control_regs_test.sv]
// self-checking bench for the receiver chain register bank
// assumes host_model drives the serial pins; bench drives the select pins
`timescale 1ns/10ps
`default_nettype none
module rx_chain_control_regs_test;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic input0_select_pin = 1'b0;
    logic input1_select_pin = 1'b0;
    wire logic sclk, cs_n, sdi, sdo, rf_input_zero, rf_input_one, attenuator_enable;
    wire logic i_path_invert, q_path_invert, i_amp_enable, q_amp_enable;
    wire logic lo_output_enable, autotune_start;
    wire logic [1:0] gain_peak, lowpass_bw_sel;
    wire logic [3:0] attenuation_code;
    wire logic [4:0] lo_divider_code;
    wire logic [2:0] lo_divide_ratio_log2;
    wire logic [7:0] demod_enables, common_mode_enables, mixer_lo_cm, mixer_out_cm;
    wire logic [7:0] dc_offset_ch0_i, dc_offset_ch0_q, dc_offset_ch1_i, dc_offset_ch1_q;
    int errors = 0; // mismatches
    int samples_checked = 0; // comparisons
    int tune_cnt = 0; // autotune pulses seen
    logic [7:0] exp_q[$]; // expected read bytes
    logic [7:0] wv [14]; // last values written to the map
    logic [15:0] map_a [14] = '{16'h0031, 16'h0032, 16'h0033, 16'h0034, 16'h003A, 16'h0040,
        16'h0051, 16'h0052, 16'h0053, 16'h0054, 16'h0060, 16'h0070, 16'h0080, 16'h1414};
    logic [7:0] sw_v [5] = '{8'h50, 8'h70, 8'h60, 8'h40, 8'h50}; // switch writes
    logic [1:0] sw_e [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h1}; // {one, zero} expected

    rx_chain_control_regs DUT (.ref_clk, .reset, .sclk, .cs_n, .sdi, .sdo, .input0_select_pin,
        .input1_select_pin, .rf_input_zero, .rf_input_one, .attenuation_code,
        .attenuator_enable, .gain_peak, .demod_enables, .common_mode_enables, .mixer_lo_cm,
        .mixer_out_cm, .dc_offset_ch0_i, .dc_offset_ch0_q, .dc_offset_ch1_i, .dc_offset_ch1_q,
        .i_path_invert, .q_path_invert, .lowpass_bw_sel, .i_amp_enable, .q_amp_enable,
        .lo_divider_code, .lo_divide_ratio_log2, .lo_output_enable, .autotune_start);
    host_model host (.ref_clk, .sclk, .cs_n, .sdi, .sdo);

    always #25 ref_clk = ~ref_clk;

    // count one-cycle autotune pulses
    always @(posedge ref_clk) begin
        if (autotune_start === 1'b1) tune_cnt++;
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic final_report();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d);
    endtask

    // expected byte is noted before the frame goes out
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(1'b1, a, 8'h00);
    endtask

    task automatic pins(input logic p0, input logic p1, input logic [1:0] e);
        @(negedge ref_clk);
        input0_select_pin = p0;
        input1_select_pin = p1;
        repeat (3) @(negedge ref_clk);
        chk("rf_sel", e, {rf_input_one, rf_input_zero});
    endtask

    // read results land here, oldest note first
    always @(host.rd_done) begin
        if (exp_q.size() == 0) errors++;
        else chk("readback", exp_q.pop_front(), host.rd_byte);
    end

    // hang guard
    initial begin
        repeat (90000) @(posedge ref_clk);
        errors++;
        final_report();
    end

    initial begin
        logic [7:0] v;
        int tc;
        v = $urandom(19849);
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("rf_off", 8'h00, {rf_input_one, rf_input_zero});
        rd(16'h0030, 8'h00);
        wr(16'h0031, 8'h3D);
        chk("att_gated", 8'h00, attenuator_enable);
        wr(16'h0020, 8'h02);
        chk("att", {4'hF, 1'b1}, {attenuation_code, attenuator_enable});
        // register select bits point at input 1, pin mode must ignore them
        wr(16'h0030, 8'h20);
        pins(1'b1, 1'b0, 2'h1);
        pins(0, 1, 2'h2);
        pins(1, 1, 2'h2);
        pins(1, 0, 2'h1);
        for (int i = 0; i < 5; i++) begin
            wr(16'h0030, sw_v[i]);
            chk("rf_sel", sw_e[i], {rf_input_one, rf_input_zero});
        end
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            wr(16'h0060, {v[7:2], i[1:0]});
            chk("lpf", i[1:0], lowpass_bw_sel);
        end
        for (int i = 0; i < 4; i++) begin
            wr(16'h1414, {3'h2, 5'h08 >> i});
            chk("div_ratio", 8'(3 - i), lo_divide_ratio_log2);
            chk("lo_output_enable", 8'h01, lo_output_enable);
        end
        for (int i = 0; i < 14; i++) begin
            wv[i] = $urandom;
            wr(map_a[i], wv[i]);
            rd(map_a[i], wv[i]);
        end
        wr(16'h0099, 8'hA5);
        rd(16'h0099, 8'h00);
        chk("att", {wv[0][5:2], wv[0][0]}, {attenuation_code, attenuator_enable});
        chk("dc0i", wv[6], dc_offset_ch0_i);
        chk("dc0q", wv[7], dc_offset_ch0_q);
        chk("dc1i", wv[8], dc_offset_ch1_i);
        chk("dc1q", wv[9], dc_offset_ch1_q);
        chk("gain", wv[4][1:0], gain_peak);
        chk("inv", wv[12][2:1], {q_path_invert, i_path_invert});
        chk("amp", wv[11][1:0], {q_amp_enable, i_amp_enable});
        chk("divc", wv[13][4:0], lo_divider_code);
        // master off clears the gated enables and leaves the rest
        wr(16'h0020, 8'h00);
        chk("gated", 8'h00, {rf_input_one, rf_input_zero, attenuator_enable, i_amp_enable,
            q_amp_enable, lo_output_enable});
        chk("gated_en", 8'h00, demod_enables | common_mode_enables);
        chk("dc_kept", wv[6], dc_offset_ch0_i);
        wr(16'h0020, 8'h02);
        wr(16'h0032, 8'h3E);
        wr(16'h0040, 8'h0F);
        wr(16'h0033, 8'h2D);
        wr(16'h0034, 8'h2D);
        chk("demod", 8'h3E, demod_enables);
        chk("cm_en", 8'h0F, common_mode_enables);
        chk("cm_lvl", 8'h2D, mixer_lo_cm & mixer_out_cm);
        tc = tune_cnt;
        wr(16'h1200, 8'h4B);
        chk("tune", 8'(tc + 1), 8'(tune_cnt));
        wr(16'h1414, 8'h41);
        chk("tune", 8'(tc + 1), 8'(tune_cnt));
        final_report();
    end
endmodule
`default_nettype wire
